// file: src/ssync_pkg.sv
// Purpose: Shared constants and types for the synchronous serial channel
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes:   Byte offsets, field positions and reset values live here
package ssync_pkg;

	// Register byte offsets
	localparam logic [7:0] SSYNC_OFS_MODE  = 8'h00;
	localparam logic [7:0] SSYNC_OFS_CTRL0 = 8'h04;
	localparam logic [7:0] SSYNC_OFS_CTRL1 = 8'h08;
	localparam logic [7:0] SSYNC_OFS_TXBUF = 8'h0c;
	localparam logic [7:0] SSYNC_OFS_RXBUF = 8'h10;
	localparam logic [7:0] SSYNC_OFS_PIN   = 8'h14;
	localparam logic [7:0] SSYNC_OFS_BRG   = 8'h18;

	// Mode register fields
	localparam int SSYNC_MODE_SYNC   = 0;
	localparam int SSYNC_MODE_CLKEXT = 3;

	// Control 0 fields
	localparam int SSYNC_C0_FLOW_FUNC = 2;
	localparam int SSYNC_C0_FLOW_DIS  = 4;
	localparam int SSYNC_C0_OPEN_DR   = 5;
	localparam int SSYNC_C0_CLK_POL   = 6;
	localparam int SSYNC_C0_MSB_FIRST = 7;

	// Control 1 fields
	localparam int SSYNC_C1_TX_EN    = 0;
	localparam int SSYNC_C1_TX_EMPTY = 1;
	localparam int SSYNC_C1_RX_EN    = 2;
	localparam int SSYNC_C1_RX_FULL  = 3;
	localparam int SSYNC_C1_OVERRUN  = 4;
	localparam int SSYNC_C1_CONT_RX  = 5;
	localparam int SSYNC_C1_DATA_INV = 6;

	// Pin configuration fields
	localparam int SSYNC_PIN_RX_DIR   = 0;
	localparam int SSYNC_PIN_CLK_DIR  = 1;
	localparam int SSYNC_PIN_MULTI    = 2;
	localparam int SSYNC_PIN_CLK_SEL  = 3;
	localparam int SSYNC_PIN_SEP_FLOW = 4;
	localparam int SSYNC_PIN_GPIO_OUT = 8;
	localparam int SSYNC_PIN_GPIO_DIR = 9;
	localparam int SSYNC_PIN_RX_LVL   = 16;
	localparam int SSYNC_PIN_FLOW_LVL = 17;

	// Reset values
	localparam logic [7:0] SSYNC_RST_CTRL0 = 8'h00;
	localparam logic [9:0] SSYNC_RST_PIN   = 10'h000;
	localparam logic [7:0] SSYNC_RST_BRG   = 8'h03;
	localparam logic [7:0] SSYNC_RST_TXBUF = 8'hff;

	// Character length and bus responses
	localparam logic [2:0] SSYNC_LAST_BIT = 3'h7;
	localparam logic [1:0] SSYNC_RESP_OK  = 2'h0;
	localparam logic [1:0] SSYNC_RESP_ERR = 2'h2;

	typedef enum logic [0:0] {
		SSYNC_IDLE  = 1'b0,
		SSYNC_SHIFT = 1'b1
	} ssync_state_t;

endpackage

// file: src/ssync_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to aclk
// Notes:   Only the second stage leaves this module
`timescale 1ns/1ps
module ssync_sync
	import ssync_pkg::*;
#(
	parameter int W = 4
)
(
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} ssync_sync_t;

	ssync_sync_t s;
	ssync_sync_t next_s;

	always_comb
	begin
		next_s.meta   = d;
		next_s.stable = s.meta;
	end

	// Pins idle high, so reset to ones
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= '1;
		else
			s <= next_s;
	end

	assign q = s.stable;

endmodule

// file: src/ssync_core.sv
// Purpose: Clock synchronous serial channel with pin options, AXI4-Lite slave
// Assumes: Pins pass two flip-flops; peer keeps its own flow and clock duties
// Notes:   One character of eight bits per transfer, full duplex
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module ssync_core
	import ssync_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Serial data pins
	output logic             serial_out_pin_o,
	output logic             serial_out_pin_oe,
	input  wire logic        serial_in_pin_i,
	// Transfer clock pins
	input  wire logic        transfer_clock_pin_i,
	output logic             transfer_clock_pin_o,
	output logic             transfer_clock_pin_oe,
	output logic             transfer_clock_alt_o,
	output logic             transfer_clock_alt_oe,
	// Flow control pins
	input  wire logic        flow_control_pin_i,
	output logic             flow_control_pin_o,
	output logic             flow_control_pin_oe,
	input  wire logic        flow_cts_alt_i
);

	typedef struct packed {
		logic         aw_held;
		logic [7:0]   awaddr;
		logic         w_held;
		logic [31:0]  wdata;
		logic [3:0]   wstrb;
		logic         bvalid;
		logic [1:0]   bresp;
		logic         rvalid;
		logic [31:0]  rdata;
		logic [1:0]   rresp;
		logic         mode_sync;
		logic         clk_ext;
		logic [7:0]   ctrl0;
		logic         tx_en;
		logic         rx_en;
		logic         cont_rx;
		logic         data_inv;
		logic         tx_empty;
		logic         rx_full;
		logic         overrun;
		logic [7:0]   txbuf;
		logic [7:0]   rxbuf;
		logic [9:0]   pin_cfg;
		logic [7:0]   brg;
		ssync_state_t state;
		logic [2:0]   cnt;
		logic [7:0]   div;
		logic         sclk;
		logic         txd;
		logic [7:0]   tsh;
		logic [7:0]   rsh;
		logic         rx_act;
		logic         cont_go;
		logic         clk_prev;
	} ssync_core_t;

	ssync_core_t s;
	ssync_core_t next_s;

	logic [3:0] sy;
	logic       sy_rx;
	logic       sy_clk;
	logic       sy_flow;
	logic       sy_cts_alt;

	ssync_sync #(
		.W (4)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({flow_cts_alt_i, flow_control_pin_i, transfer_clock_pin_i, serial_in_pin_i}),
		.q       (sy)
	);

	assign sy_rx      = sy[0];
	assign sy_clk     = sy[1];
	assign sy_flow    = sy[2];
	assign sy_cts_alt = sy[3];

	// Address decode shared by read and write: {valid, word index}
	function automatic logic [3:0] ssync_decode(input logic [7:0] a);
		logic [2:0] idx;
		idx = a[4:2];
		ssync_decode = {(a[1:0] == 2'h0) && (a[7:5] == 3'h0) && (idx <= 3'h6), idx};
	endfunction

	// Byte-lane merge for partial writes
	function automatic logic [31:0] ssync_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (st[i])
				r[i*8 +: 8] = wd[i*8 +: 8];
		end
		ssync_merge = r;
	endfunction

	logic multi_on;
	logic sep_on;
	logic flow_gpio;
	logic use_cts;
	logic use_rts;
	logic cts_level;
	logic rts_level;
	logic idle_lvl;
	logic ext_ok;
	logic start_ok;

	assign multi_on  = s.pin_cfg[SSYNC_PIN_MULTI] && !s.clk_ext;
	// separate pins yield to multi-pin clock
	assign sep_on    = s.pin_cfg[SSYNC_PIN_SEP_FLOW] && !multi_on;
	assign flow_gpio = s.ctrl0[SSYNC_C0_FLOW_DIS] || multi_on;
	assign use_cts   = !flow_gpio && (sep_on || !s.ctrl0[SSYNC_C0_FLOW_FUNC]);
	assign use_rts   = !flow_gpio && (sep_on || s.ctrl0[SSYNC_C0_FLOW_FUNC]);
	assign cts_level = sep_on ? sy_cts_alt : sy_flow;
	// Low while a received character would have room
	assign rts_level = !(s.rx_en && !s.rx_full);
	assign idle_lvl  = !s.ctrl0[SSYNC_C0_CLK_POL];
	// external clock needs pin direction input
	assign ext_ok    = !s.pin_cfg[SSYNC_PIN_CLK_DIR] && (sy_clk == idle_lvl);
	assign start_ok  = s.mode_sync && s.tx_en && (!s.tx_empty || s.cont_go) &&
	                   (!use_cts || !cts_level) && (!s.clk_ext || ext_ok);

	always_comb
	begin
		logic [3:0]  rdec;
		logic [3:0]  wdec;
		logic [31:0] rd;
		logic [31:0] wv;
		logic        tog;
		logic        lead;
		logic        trail;
		logic [7:0]  rnext;
		logic        rearm;
		rdec  = ssync_decode(s_axi_araddr);
		wdec  = ssync_decode(s.awaddr);
		rd    = 32'h0;
		wv    = 32'h0;
		tog   = 1'b0;
		lead  = 1'b0;
		trail = 1'b0;
		rnext = 8'h0;
		rearm = 1'b0;
		next_s = s;
		next_s.clk_prev = sy_clk;

		// Read channel, side effects at address acceptance
		if (s.rvalid && s_axi_rready)
			next_s.rvalid = 1'b0;
		if (s_axi_arvalid && !s.rvalid)
		begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = rdec[3] ? SSYNC_RESP_OK : SSYNC_RESP_ERR;
			case ({rdec[3], rdec[2:0]})
				{1'b1, SSYNC_OFS_MODE[4:2]}:
				begin
					rd[SSYNC_MODE_SYNC]   = s.mode_sync;
					rd[SSYNC_MODE_CLKEXT] = s.clk_ext;
				end
				{1'b1, SSYNC_OFS_CTRL0[4:2]}: rd[7:0] = s.ctrl0;
				{1'b1, SSYNC_OFS_CTRL1[4:2]}:
				begin
					rd[SSYNC_C1_TX_EN]    = s.tx_en;
					rd[SSYNC_C1_TX_EMPTY] = s.tx_empty;
					rd[SSYNC_C1_RX_EN]    = s.rx_en;
					rd[SSYNC_C1_RX_FULL]  = s.rx_full;
					rd[SSYNC_C1_OVERRUN]  = s.overrun;
					rd[SSYNC_C1_CONT_RX]  = s.cont_rx;
					rd[SSYNC_C1_DATA_INV] = s.data_inv;
				end
				{1'b1, SSYNC_OFS_RXBUF[4:2]}:
				begin
					rd[7:0] = s.data_inv ? ~s.rxbuf : s.rxbuf;
					next_s.rx_full = 1'b0;
					next_s.overrun = 1'b0;
					if (s.cont_rx && s.rx_en && s.tx_en)
						rearm = 1'b1;
				end
				{1'b1, SSYNC_OFS_PIN[4:2]}:
				begin
					rd[9:0] = s.pin_cfg;
					// pin level readable as a port
					rd[SSYNC_PIN_RX_LVL]   = sy_rx;
					rd[SSYNC_PIN_FLOW_LVL] = sy_flow;
				end
				{1'b1, SSYNC_OFS_BRG[4:2]}: rd[7:0] = s.brg;
				default: rd = 32'h0;
			endcase
			next_s.rdata = rd;
		end

		// Serial engine
		case (s.state)
			SSYNC_IDLE:
			begin
				next_s.txd  = 1'b1;
				next_s.sclk = idle_lvl;
				next_s.div  = 8'h0;
				if (start_ok)
				begin
					next_s.state    = SSYNC_SHIFT;
					// dummy data shifts even when receiving only
					next_s.tsh      = s.txbuf;
					next_s.tx_empty = 1'b1;
					next_s.cnt      = 3'h0;
					next_s.cont_go  = 1'b0;
					// receive needs enable and input direction
					next_s.rx_act   = s.rx_en && !s.pin_cfg[SSYNC_PIN_RX_DIR];
				end
			end
			SSYNC_SHIFT:
			begin
				if (!s.clk_ext)
				begin
					// internal half period of brg+1 cycles
					if (s.div == s.brg)
					begin
						next_s.div  = 8'h0;
						next_s.sclk = ~s.sclk;
						tog         = 1'b1;
					end
					else
						next_s.div = s.div + 8'h1;
					lead  = tog && (s.sclk == idle_lvl);
					trail = tog && (s.sclk != idle_lvl);
				end
				else
				begin
					lead  = (s.clk_prev == idle_lvl) && (sy_clk != idle_lvl);
					trail = (s.clk_prev != idle_lvl) && (sy_clk == idle_lvl);
				end
				// shift on leading edge, sample on trailing
				if (lead)
				begin
					if (s.ctrl0[SSYNC_C0_MSB_FIRST])
					begin
						next_s.txd = s.tsh[7];
						next_s.tsh = {s.tsh[6:0], 1'b1};
					end
					else
					begin
						next_s.txd = s.tsh[0];
						next_s.tsh = {1'b1, s.tsh[7:1]};
					end
				end
				if (trail)
				begin
					rnext = s.ctrl0[SSYNC_C0_MSB_FIRST] ? {s.rsh[6:0], sy_rx} : {sy_rx, s.rsh[7:1]};
					next_s.rsh = rnext;
					next_s.cnt = s.cnt + 3'h1;
					if (s.cnt == SSYNC_LAST_BIT)
					begin
						next_s.state = SSYNC_IDLE;
						if (s.rx_act)
						begin
							// Unread data is overwritten, flagged as overrun
							if (next_s.rx_full)
								next_s.overrun = 1'b1;
							next_s.rxbuf   = rnext;
							next_s.rx_full = 1'b1;
						end
					end
				end
				if (!s.mode_sync)
					next_s.state = SSYNC_IDLE;
			end
			default: next_s.state = SSYNC_IDLE;
		endcase

		// Re-arm from a read outlives a start in the same cycle
		if (rearm)
			next_s.cont_go = 1'b1;

		// Write channel, after the engine so new data is not lost
		if (s.bvalid && s_axi_bready)
			next_s.bvalid = 1'b0;
		if (s_axi_awvalid && !s.aw_held && !s.bvalid)
		begin
			next_s.aw_held = 1'b1;
			next_s.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s.w_held && !s.bvalid)
		begin
			next_s.w_held = 1'b1;
			next_s.wdata  = s_axi_wdata;
			next_s.wstrb  = s_axi_wstrb;
		end
		if (s.aw_held && s.w_held && !s.bvalid)
		begin
			next_s.aw_held = 1'b0;
			next_s.w_held  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = wdec[3] ? SSYNC_RESP_OK : SSYNC_RESP_ERR;
			case ({wdec[3], wdec[2:0]})
				{1'b1, SSYNC_OFS_MODE[4:2]}:
				begin
					wv = ssync_merge({28'h0, s.clk_ext, 2'h0, s.mode_sync}, s.wdata, s.wstrb);
					next_s.mode_sync = wv[SSYNC_MODE_SYNC];
					next_s.clk_ext   = wv[SSYNC_MODE_CLKEXT];
				end
				{1'b1, SSYNC_OFS_CTRL0[4:2]}:
				begin
					wv = ssync_merge({24'h0, s.ctrl0}, s.wdata, s.wstrb);
					next_s.ctrl0 = wv[7:0];
				end
				{1'b1, SSYNC_OFS_CTRL1[4:2]}:
				begin
					wv = ssync_merge({25'h0, s.data_inv, s.cont_rx, 2'h0, s.rx_en, 1'b0, s.tx_en}, s.wdata, s.wstrb);
					next_s.tx_en    = wv[SSYNC_C1_TX_EN];
					next_s.rx_en    = wv[SSYNC_C1_RX_EN];
					next_s.cont_rx  = wv[SSYNC_C1_CONT_RX];
					next_s.data_inv = wv[SSYNC_C1_DATA_INV];
				end
				{1'b1, SSYNC_OFS_TXBUF[4:2]}:
				begin
					if (s.wstrb[0])
					begin
						next_s.txbuf    = s.data_inv ? ~s.wdata[7:0] : s.wdata[7:0];
						next_s.tx_empty = 1'b0;
					end
				end
				{1'b1, SSYNC_OFS_PIN[4:2]}:
				begin
					wv = ssync_merge({22'h0, s.pin_cfg}, s.wdata, s.wstrb);
					next_s.pin_cfg = wv[9:0];
				end
				{1'b1, SSYNC_OFS_BRG[4:2]}:
				begin
					wv = ssync_merge({24'h0, s.brg}, s.wdata, s.wstrb);
					next_s.brg = wv[7:0];
				end
				default: wv = 32'h0;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s          <= '0;
			s.ctrl0    <= SSYNC_RST_CTRL0;
			s.pin_cfg  <= SSYNC_RST_PIN;
			s.brg      <= SSYNC_RST_BRG;
			s.txbuf    <= SSYNC_RST_TXBUF;
			s.tx_empty <= 1'b1;
			s.state    <= SSYNC_IDLE;
			s.sclk     <= 1'b1;
			s.txd      <= 1'b1;
			s.clk_prev <= 1'b1;
		end
		else
			s <= next_s;
	end

	// Bus outputs
	assign s_axi_awready = !s.aw_held && !s.bvalid;
	assign s_axi_wready  = !s.w_held && !s.bvalid;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rdata   = s.rdata;
	assign s_axi_rresp   = s.rresp;

	assign serial_out_pin_o  = s.txd && !s.ctrl0[SSYNC_C0_OPEN_DR];
	assign serial_out_pin_oe = s.mode_sync && !(s.ctrl0[SSYNC_C0_OPEN_DR] && s.txd);

	// clock drives one of two pins
	assign transfer_clock_pin_o  = s.sclk;
	assign transfer_clock_pin_oe = s.mode_sync && !s.clk_ext && !(multi_on && s.pin_cfg[SSYNC_PIN_CLK_SEL]);
	assign transfer_clock_alt_o  = s.sclk;
	assign transfer_clock_alt_oe = s.mode_sync && multi_on && s.pin_cfg[SSYNC_PIN_CLK_SEL];

	assign flow_control_pin_o  = flow_gpio ? s.pin_cfg[SSYNC_PIN_GPIO_OUT] : rts_level;
	assign flow_control_pin_oe = flow_gpio ? s.pin_cfg[SSYNC_PIN_GPIO_DIR] : (use_rts && s.mode_sync);

endmodule

// file: bench/ssync_core_asserts.sv
// Purpose: Port checks for the serial channel core
// Assumes: One aclk domain, synchronous active-low reset
// Notes:   Bound into every core instance
`timescale 1ns/1ps
module ssync_core_asserts
	import ssync_pkg::*;
(
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Pin enables
	input wire logic        serial_out_pin_oe,
	input wire logic        transfer_clock_pin_oe,
	input wire logic        transfer_clock_alt_oe
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	aw_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write ready while response pending");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[2:3] s_axi_bvalid)
		else $error("write response late");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp}))
		else $error("read data dropped early");
	r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	ar_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while data pending");
	clk_single_a: assert property (!(transfer_clock_pin_oe && transfer_clock_alt_oe))
		else $error("both clock pins driven");
	rst_quiet_a: assert property ($rose(aresetn) |-> !serial_out_pin_oe && !transfer_clock_pin_oe && !transfer_clock_alt_oe)
		else $error("pin driven straight after reset");

	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property ($rose(transfer_clock_alt_oe));
endmodule

bind ssync_core ssync_core_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_out_pin_oe, .transfer_clock_pin_oe, .transfer_clock_alt_oe);

// file: bench/ssync_peer.sv
// Purpose: Behavioural remote peer on the synchronous serial link
// Assumes: Bench resolves the clock and data line levels
// Notes:   Supplies the link clock only inside frames
`timescale 1ns/1ps
module ssync_peer
(
	// Link lines
	input  wire logic       sclk,
	input  wire logic       sdo,
	output logic            sdi,
	output logic            ext_clk,
	// Frame format
	input  wire logic       pol,
	input  wire logic       msb,
	input  wire logic [7:0] tx_byte,
	output logic [7:0]      rx_byte
);
	int cnt;

	initial
	begin
		sdi = 1'b1;
		ext_clk = 1'b1;
		cnt = 8;
	end

	// Idle level first, so its step is not counted as an edge
	task automatic arm();
		ext_clk = ~pol;
		#1;
		cnt = 0;
	endtask

	task automatic ext_frame();
		repeat (8)
		begin
			#80;
			ext_clk = pol;
			#80;
			ext_clk = ~pol;
		end
	endtask

	always @(sclk)
	begin
		if (cnt < 8 && sclk === pol)
			sdi = tx_byte[msb ? 3'(7 - cnt) : 3'(cnt)];
		else if (cnt < 8 && sclk === !pol)
		begin
			rx_byte = msb ? {rx_byte[6:0], sdo} : {sdo, rx_byte[7:1]};
			cnt = cnt + 1;
			// Hold over: never leave the last bit showing
			// Late enough that the synchronised last sample is already taken
			if (cnt == 8)
				sdi <= #20 ~sdi;
		end
	end
endmodule

// file: bench/tb_sync_serial_pin_and_options.sv
// Purpose: Register-level tests of the serial channel core
// Assumes: Peer model on the link, 250 MHz aclk
// Notes:   Transfers are judged at both the peer and the receive buffer
`timescale 1ns/1ps
module tb_sync_serial_pin_and_options
	import ssync_pkg::*;
;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        serial_out_pin_o, serial_out_pin_oe, serial_in_pin_i, transfer_clock_pin_i;
	logic        transfer_clock_pin_o, transfer_clock_pin_oe, transfer_clock_alt_o, transfer_clock_alt_oe;
	logic        flow_control_pin_i, flow_control_pin_o, flow_control_pin_oe, flow_cts_alt_i;
	logic        cts_drv, pol, msb, ext, ext_clk, sclk, sdo;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, pbyte, prx;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          mismatches, tests_run;

	assign transfer_clock_pin_i = transfer_clock_pin_oe ? transfer_clock_pin_o : ext_clk;
	assign sclk = transfer_clock_alt_oe ? transfer_clock_alt_o : transfer_clock_pin_i;
	// Pull-up holds a released data line high
	assign sdo = serial_out_pin_oe ? serial_out_pin_o : 1'b1;
	assign flow_control_pin_i = flow_control_pin_oe ? flow_control_pin_o : cts_drv;

	ssync_core DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.serial_out_pin_o(serial_out_pin_o), .serial_out_pin_oe(serial_out_pin_oe), .serial_in_pin_i(serial_in_pin_i),
		.transfer_clock_pin_i(transfer_clock_pin_i), .transfer_clock_pin_o(transfer_clock_pin_o),
		.transfer_clock_pin_oe(transfer_clock_pin_oe), .transfer_clock_alt_o(transfer_clock_alt_o),
		.transfer_clock_alt_oe(transfer_clock_alt_oe), .flow_control_pin_i(flow_control_pin_i),
		.flow_control_pin_o(flow_control_pin_o), .flow_control_pin_oe(flow_control_pin_oe),
		.flow_cts_alt_i(flow_cts_alt_i));
	ssync_peer peer (.sclk(sclk), .sdo(sdo), .sdi(serial_in_pin_i), .ext_clk(ext_clk), .pol(pol), .msb(msb),
		.tx_byte(pbyte), .rx_byte(prx));

	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic fail(input string s);
		mismatches++;
		$display("unexpected at %0t: %s", $time, s);
		report_and_stop();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = SSYNC_RESP_OK);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 100);
		if (n == 100)
			fail("write hung");
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(er));
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = SSYNC_RESP_OK);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		if (n == 100)
			fail("read hung");
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
		chk(32'(s_axi_rresp), 32'(er));
	endtask

	task automatic poll();
		int n;
		n = 0;
		do
		begin
			rd(SSYNC_OFS_CTRL1, rv);
			n++;
		end while (rv[SSYNC_C1_RX_FULL] !== 1'b1 && n < 200);
		if (n == 200)
			fail("character never arrived");
	endtask

	task automatic go(input logic [7:0] d, input logic [7:0] p);
		pbyte = p;
		peer.arm();
		wr(SSYNC_OFS_TXBUF, 32'(d));
		if (ext)
		begin
			repeat (10) @(posedge aclk);
			peer.ext_frame();
		end
		poll();
	endtask

	task automatic pair(input logic [7:0] tx, input logic [7:0] rx);
		chk(32'(prx), 32'(tx));
		rd(SSYNC_OFS_RXBUF, rv);
		chk(rv, 32'(rx));
	endtask

	initial
	begin
		mismatches = 0;
		tests_run = 0;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{pol, msb, ext} = '0;
		{cts_drv, flow_cts_alt_i, pbyte} = '0;
		s_axi_wstrb = 4'hf;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(SSYNC_OFS_CTRL1, rv);
		chk(rv, 32'h2);
		rd(SSYNC_OFS_BRG, rv);
		chk(rv, 32'(SSYNC_RST_BRG));
		rd(8'h40, rv, SSYNC_RESP_ERR);
		chk(rv, 32'h0);
		wr(8'h40, 32'hffffffff, SSYNC_RESP_ERR);
		wr(SSYNC_OFS_MODE, 32'h1);
		chk(32'({serial_out_pin_oe, serial_out_pin_o}), 32'h3);
		wr(SSYNC_OFS_CTRL0, 32'h20);
		chk(32'(serial_out_pin_oe), 32'h0);
		wr(SSYNC_OFS_CTRL1, 32'h5);
		$display("test idle levels finished");
		for (int i = 0; i < 4; i++)
		begin
			pol = i[0];
			msb = i[1];
			wr(SSYNC_OFS_CTRL0, 32'h10 | 32'(i << 6));
			go(8'hb1, 8'h4e);
			chk(32'(transfer_clock_pin_o), 32'(!pol));
			pair(8'hb1, 8'h4e);
		end
		$display("test polarity and order finished");
		wr(SSYNC_OFS_CTRL1, 32'h45);
		go(8'h96, 8'h21);
		pair(8'h69, 8'hde);
		wr(SSYNC_OFS_CTRL1, 32'h25);
		go(8'h3c, 8'hc5);
		chk(32'(prx), 32'h3c);
		pbyte = 8'h5a;
		peer.arm();
		rd(SSYNC_OFS_RXBUF, rv);
		chk(rv, 32'hc5);
		poll();
		wr(SSYNC_OFS_CTRL1, 32'h5);
		pair(8'h3c, 8'h5a);
		$display("test invert and continuous finished");
		cts_drv <= 1'b1;
		wr(SSYNC_OFS_CTRL0, 32'hc0);
		chk(32'(flow_control_pin_oe), 32'h0);
		pbyte = 8'h0f;
		peer.arm();
		wr(SSYNC_OFS_TXBUF, 32'h81);
		repeat (40) @(posedge aclk);
		rd(SSYNC_OFS_CTRL1, rv);
		chk(rv, 32'h5);
		cts_drv <= 1'b0;
		poll();
		pair(8'h81, 8'h0f);
		wr(SSYNC_OFS_CTRL0, 32'hc4);
		chk(32'({flow_control_pin_oe, flow_control_pin_o}), 32'h2);
		wr(SSYNC_OFS_CTRL0, 32'hd0);
		wr(SSYNC_OFS_PIN, 32'h300);
		chk(32'({flow_control_pin_oe, flow_control_pin_o}), 32'h3);
		rd(SSYNC_OFS_PIN, rv);
		chk(rv, 32'h20300 | (32'(serial_in_pin_i) << 16));
		wr(SSYNC_OFS_CTRL0, 32'hc0);
		flow_cts_alt_i <= 1'b1;
		wr(SSYNC_OFS_PIN, 32'h010);
		chk(32'({flow_control_pin_oe, flow_control_pin_o}), 32'h2);
		pbyte = 8'h33;
		peer.arm();
		wr(SSYNC_OFS_TXBUF, 32'hcc);
		repeat (40) @(posedge aclk);
		rd(SSYNC_OFS_CTRL1, rv);
		chk(rv, 32'h5);
		flow_cts_alt_i <= 1'b0;
		poll();
		pair(8'hcc, 8'h33);
		$display("test flow pin finished");
		flow_cts_alt_i <= 1'b1;
		wr(SSYNC_OFS_CTRL0, 32'hc4);
		wr(SSYNC_OFS_PIN, 32'h01c);
		chk(32'({transfer_clock_alt_oe, transfer_clock_pin_oe, flow_control_pin_oe}), 32'h4);
		go(8'he7, 8'h18);
		pair(8'he7, 8'h18);
		wr(SSYNC_OFS_MODE, 32'h9);
		chk(32'({transfer_clock_alt_oe, transfer_clock_pin_oe}), 32'h0);
		wr(SSYNC_OFS_PIN, 32'h0);
		wr(SSYNC_OFS_CTRL0, 32'hd0);
		ext = 1'b1;
		go(8'h5c, 8'ha3);
		chk(32'(transfer_clock_pin_oe), 32'h0);
		pair(8'h5c, 8'ha3);
		$display("test clock pins finished");
		report_and_stop();
	end
endmodule
